// file: bench/scg_link_sva.sv
// Concurrent checks on the register link between host and device ends
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_link_sva
    import scg_pkg::*;
(
    input wire logic      sys_clk,
    input wire logic      arst_n,
    input wire logic      wr,
    input wire logic      rd,
    input wire scg_addr_t addr,
    input wire scg_data_t wdata,
    input wire scg_data_t rdata,
    input wire logic      rvalid,
    input wire logic      irq_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Decode and helper state
    // ****************************************
    wire logic stat_sel = (addr == `SCG_OFS_IRQ_STAT_A) || (addr == `SCG_OFS_IRQ_STAT_A2);
    wire logic clr_wr   = wr && stat_sel && wdata[`SCG_IRQ_RESET_BIT];
    logic      seen_irq_q;

    // Remembers that the device has finished start-up once
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            seen_irq_q <= 1'b0;
        else if (!irq_n)
            seen_irq_q <= 1'b1;
    end

    sequence s_key;
        wr && addr == `SCG_OFS_UNLOCK_KEY && wdata[7:0] == `SCG_KEY_VALUE;
    endsequence
    sequence s_cfg;
        wr && addr == `SCG_OFS_TIMING_CFG && wdata[7:0] == `SCG_TIMING_OPTIMUM;
    endsequence
    sequence s_clr;
        clr_wr;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    chk_rvalid_cause: assert property (rvalid |-> $past(rd))
        else $error("read answer without a read strobe");
    chk_strobe_excl: assert property (!(wr && rd))
        else $error("write and read strobes together");
    chk_wait_irq: assert property ((wr || rd) |-> seen_irq_q || !irq_n)
        else $error("link access before the start-up interrupt");
    chk_bringup_seq: assert property ($fell(irq_n) |-> ##[1:6] s_key ##1 s_cfg ##1 s_clr)
        else $error("unlock, timing write and clear not back to back");
    chk_irq_clear: assert property (clr_wr && !irq_n |=> irq_n)
        else $error("interrupt pin stays low after clear");
    chk_gain_a_range: assert property (rvalid && $past(addr) == `SCG_OFS_CHAN_A_GAIN |-> rdata <= 24'h5)
        else $error("channel a gain code out of range");
    chk_gain_bv_range: assert property (rvalid && ($past(addr) == `SCG_OFS_CHAN_B_GAIN
        || $past(addr) == `SCG_OFS_VOLT_GAIN) |-> rdata <= 24'h4)
        else $error("channel b or voltage gain code out of range");
    chk_status_flag: assert property (rvalid && $past(stat_sel) |-> rdata[20] == !$past(irq_n))
        else $error("reset flag disagrees with interrupt pin");
    chk_key_reads_zero: assert property (rvalid && $past(addr) == `SCG_OFS_UNLOCK_KEY |-> rdata == 24'h0)
        else $error("key register read not zero");
endmodule : scg_link_sva

// file: bench/tb_top.sv
// Self-checking bench for start-up sequencing and gain configuration
`timescale 1ns/100ps
`include "scg_map.svh"
module tb_top;
    localparam int HOLD_CYC   = 20;
    localparam int ENABLE_CYC = 30;
    localparam int START_CYC  = HOLD_CYC + ENABLE_CYC + 3;
    localparam int LIMIT_CYC  = 20000;

    logic        sys_clk;
    logic        arst_n;
    logic        supply_ok;
    logic        sw_reset;
    logic [3:0]  cmd_addr;
    logic [23:0] cmd_wdata;
    logic        cmd_wr;
    logic        cmd_rd;
    logic [23:0] cmd_rdata;
    logic [2:0]  volt_gain_code;
    logic [2:0]  chan_a_gain_code;
    logic [2:0]  chan_b_gain_code;
    logic [7:0]  timing_cfg;
    logic        active;
    logic [23:0] rd_val;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;

    scg_if link ();

    scg_device #(.HOLD_CYC (HOLD_CYC), .ENABLE_CYC (ENABLE_CYC)) i_scg_device (
        .sys_clk          (sys_clk),
        .arst_n           (arst_n),
        .supply_ok        (supply_ok),
        .sw_reset         (sw_reset),
        .bus              (link),
        .volt_gain_code   (volt_gain_code),
        .chan_a_gain_code (chan_a_gain_code),
        .chan_b_gain_code (chan_b_gain_code),
        .timing_cfg       (timing_cfg),
        .active           (active)
    );
    scg_host #(.TIMEOUT_CYC (100)) i_scg_host (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .bus       (link),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .cmd_wr    (cmd_wr),
        .cmd_rd    (cmd_rd),
        .cmd_rdata (cmd_rdata)
    );
    scg_link_sva i_scg_link_sva (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wr      (link.wr),
        .rd      (link.rd),
        .addr    (link.addr),
        .wdata   (link.wdata),
        .rdata   (link.rdata),
        .rvalid  (link.rvalid),
        .irq_n   (link.irq_n)
    );

    // ****************************************
    // Clock, hang guard and verdict
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever
            #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT_CYC)
        begin
            n_fail = n_fail + 1;
            results();
        end
    end

    task automatic results();
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ****************************************
    // Command port and relayed device accesses
    // ****************************************
    task automatic hwr(input logic [3:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        cmd_addr  <= a;
        cmd_wdata <= d;
        cmd_wr    <= 1'b1;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
    endtask : hwr

    task automatic hrd(input logic [3:0] a, output logic [23:0] d);
        @(posedge sys_clk);
        cmd_addr <= a;
        cmd_rd   <= 1'b1;
        @(posedge sys_clk);
        cmd_rd <= 1'b0;
        @(negedge sys_clk);
        d = cmd_rdata;
    endtask : hrd

    // Polls until the relay is idle with no read in flight
    task automatic wait_idle();
        logic [23:0] st;
        int          n;
        n = 0;
        hrd(`SCG_HOFS_STATUS, st);
        while ((st[0] !== 1'b1 || st[2] !== 1'b0) && n < 400)
        begin
            hrd(`SCG_HOFS_STATUS, st);
            n++;
        end
        check({21'h0, st[2:0]} & 24'h5, 24'h1);
    endtask : wait_idle

    task automatic dwr(input logic [9:0] a, input logic [23:0] d);
        hwr(`SCG_HOFS_DEV_ADDR, {14'h0, a});
        hwr(`SCG_HOFS_DEV_WDATA, d);
        hwr(`SCG_HOFS_DEV_GO, 24'h1);
        wait_idle();
    endtask : dwr

    task automatic drd(input logic [9:0] a, output logic [23:0] d);
        hwr(`SCG_HOFS_DEV_ADDR, {14'h0, a});
        hwr(`SCG_HOFS_DEV_GO, 24'h2);
        wait_idle();
        hrd(`SCG_HOFS_DEV_RDATA, d);
    endtask : drd

    // Counts edges until active, then lets the host finish its bring-up
    task automatic startup(input int exp_n);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            sw_reset <= 1'b0;
            #1;
            n++;
        end
        while (active !== 1'b1 && n < 200);
        check(24'(n), 24'(exp_n));
        check({23'h0, link.irq_n}, 24'h0);
        n = 0;
        while (link.irq_n !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        wait_idle();
        check({7'h0, timing_cfg, volt_gain_code, chan_a_gain_code, chan_b_gain_code}, 24'h6000);
    endtask : startup

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        arst_n    = 1'b0;
        supply_ok = 1'b0;
        sw_reset  = 1'b0;
        cmd_addr  = 4'h0;
        cmd_wdata = 24'h0;
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check({22'h0, active, link.irq_n}, 24'h1);
        supply_ok <= 1'b1;
        startup(START_CYC);
        hrd(`SCG_HOFS_CTRL, rd_val);
        check(rd_val, 24'h1);
        for (int ch = 0; ch < 3; ch++)
            for (int code = 0; code < 8; code++)
            begin
                dwr(10'(`SCG_OFS_VOLT_GAIN + ch), 24'(code));
                drd(10'(`SCG_OFS_VOLT_GAIN + ch), rd_val);
                check(rd_val, 24'(code <= (ch == 1 ? 5 : 4) ? code : (ch == 1 ? 5 : 4)));
            end
        check({15'h0, volt_gain_code, chan_a_gain_code, chan_b_gain_code}, 24'h12c);
        dwr(`SCG_OFS_TIMING_CFG, 24'h55);
        check({16'h0, timing_cfg}, 24'h30);
        dwr(`SCG_OFS_UNLOCK_KEY, 24'had);
        dwr(`SCG_OFS_TIMING_CFG, 24'h55);
        check({16'h0, timing_cfg}, 24'h55);
        dwr(`SCG_OFS_UNLOCK_KEY, 24'hac);
        dwr(`SCG_OFS_TIMING_CFG, 24'h66);
        check({16'h0, timing_cfg}, 24'h55);
        dwr(`SCG_OFS_UNLOCK_KEY, 24'had);
        drd(`SCG_OFS_UNLOCK_KEY, rd_val);
        check(rd_val, 24'h0);
        dwr(`SCG_OFS_TIMING_CFG, 24'h66);
        check({16'h0, timing_cfg}, 24'h55);
        dwr(`SCG_OFS_UNLOCK_KEY, 24'had);
        dwr(`SCG_OFS_CHAN_A_GAIN, 24'h1);
        dwr(`SCG_OFS_TIMING_CFG, 24'h66);
        drd(`SCG_OFS_TIMING_CFG, rd_val);
        check(rd_val, 24'h55);
        drd(`SCG_OFS_IRQ_STAT_A2, rd_val);
        check(rd_val, 24'h0);
        drd(10'h3ff, rd_val);
        check(rd_val, 24'h0);
        @(posedge sys_clk);
        sw_reset <= 1'b1;
        startup(ENABLE_CYC + 2);
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({22'h0, active, link.irq_n}, 24'h1);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        startup(START_CYC);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        check({7'h0, timing_cfg, volt_gain_code, chan_a_gain_code, chan_b_gain_code}, 24'h0);
        arst_n <= 1'b1;
        startup(START_CYC);
        results();
    end
endmodule : tb_top

// file: verilog/scg_device.sv
// Device end: power-up sequencer, unlock key, gain select and interrupt status registers
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_device
    import scg_pkg::*;
#(
    parameter int unsigned HOLD_CYC   = `SCG_HOLD_CYC,
    parameter int unsigned ENABLE_CYC = `SCG_ENABLE_CYC
) (
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    input  wire logic  supply_ok,
    input  wire logic  sw_reset,
    scg_if.dev         bus,
    output logic [2:0] volt_gain_code,
    output logic [2:0] chan_a_gain_code,
    output logic [2:0] chan_b_gain_code,
    output logic [7:0] timing_cfg,
    output logic       active
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic gain_ok(input logic [2:0] code, input logic [2:0] max_code);
        gain_ok = (code <= max_code);
    endfunction : gain_ok

    // ****************************************
    // Start-up sequencer
    // ****************************************
    scg_dev_state_e state_q;
    scg_dev_state_e state_d;
    logic           tmr_done;
    logic           tmr_clr;
    logic [31:0]    tmr_limit;
    logic           ready;
    logic           reinit;
    logic           startup_done;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SCG_DEV_OFF:
                if (supply_ok)
                    state_d = SCG_DEV_HOLD;
            // RQ2 hold-off delay
            SCG_DEV_HOLD:
                if (tmr_done)
                    state_d = SCG_DEV_ENABLE;
            // RQ3 enable interval
            SCG_DEV_ENABLE:
                if (tmr_done)
                    state_d = SCG_DEV_READY;
            SCG_DEV_READY:
                if (sw_reset)
                    state_d = SCG_DEV_ENABLE;
            default:
                state_d = SCG_DEV_OFF;
        endcase
        // RQ1 supply low forces off
        if (!supply_ok)
            state_d = SCG_DEV_OFF;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= SCG_DEV_OFF;
        else
            state_q <= state_d;
    end

    // One counter serves both phases; it restarts on every state change
    assign tmr_clr      = (state_q != state_d) || (state_q == SCG_DEV_OFF) || (state_q == SCG_DEV_READY);
    assign tmr_limit    = (state_q == SCG_DEV_HOLD) ? HOLD_CYC : ENABLE_CYC;
    assign startup_done = (state_q == SCG_DEV_ENABLE) && (state_d == SCG_DEV_READY);
    assign ready        = (state_q == SCG_DEV_READY);
    assign reinit       = !ready;
    assign active       = ready;

    scg_timer #(
        .W (32)
    ) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clr     (tmr_clr),
        .limit   (tmr_limit),
        .done    (tmr_done)
    );

    // ****************************************
    // Access decode
    // ****************************************
    logic acc_wr;
    logic acc_rd;
    logic sel_volt;
    logic sel_chan_a;
    logic sel_chan_b;
    logic sel_key;
    logic sel_timing;
    logic sel_irq;
    logic key_hit;
    logic irq_clr;

    // RQ1 traffic ignored while inactive
    assign acc_wr     = bus.wr && ready;
    assign acc_rd     = bus.rd && ready;
    assign sel_volt   = (bus.addr == `SCG_OFS_VOLT_GAIN);
    assign sel_chan_a = (bus.addr == `SCG_OFS_CHAN_A_GAIN);
    assign sel_chan_b = (bus.addr == `SCG_OFS_CHAN_B_GAIN);
    assign sel_key    = (bus.addr == `SCG_OFS_UNLOCK_KEY);
    assign sel_timing = (bus.addr == `SCG_OFS_TIMING_CFG);
    assign sel_irq    = (bus.addr == `SCG_OFS_IRQ_STAT_A) || (bus.addr == `SCG_OFS_IRQ_STAT_A2);
    assign key_hit    = acc_wr && sel_key && (bus.wdata[7:0] == `SCG_KEY_VALUE);
    assign irq_clr    = acc_wr && sel_irq && bus.wdata[`SCG_IRQ_RESET_BIT];

    // ****************************************
    // Gain select registers
    // ****************************************
    logic [2:0] volt_gain_q;
    logic [2:0] chan_a_gain_q;
    logic [2:0] chan_b_gain_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // RQ15 RQ18 RQ20 gain one
            volt_gain_q   <= `SCG_GAIN_RESET;
            chan_a_gain_q <= `SCG_GAIN_RESET;
            chan_b_gain_q <= `SCG_GAIN_RESET;
        end
        else if (reinit)
        begin
            volt_gain_q   <= `SCG_GAIN_RESET;
            chan_a_gain_q <= `SCG_GAIN_RESET;
            chan_b_gain_q <= `SCG_GAIN_RESET;
        end
        else
        begin
            // RQ19 voltage codes
            if (acc_wr && sel_volt && gain_ok(bus.wdata[2:0], `SCG_GAIN_MAX_BV))
                volt_gain_q <= bus.wdata[2:0];
            // RQ14 channel A codes
            if (acc_wr && sel_chan_a && gain_ok(bus.wdata[2:0], `SCG_GAIN_MAX_A))
                chan_a_gain_q <= bus.wdata[2:0];
            // RQ16 RQ17 no gain 22 on B
            if (acc_wr && sel_chan_b && gain_ok(bus.wdata[2:0], `SCG_GAIN_MAX_BV))
                chan_b_gain_q <= bus.wdata[2:0];
        end
    end

    assign volt_gain_code   = volt_gain_q;
    assign chan_a_gain_code = chan_a_gain_q;
    assign chan_b_gain_code = chan_b_gain_q;

    // ****************************************
    // Protected timing register
    // ****************************************
    logic       unlock_q;
    logic [7:0] timing_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            unlock_q <= 1'b0;
        else if (reinit)
            unlock_q <= 1'b0;
        // RQ21 any access re-decides unlock
        else if (acc_wr || acc_rd)
            unlock_q <= key_hit;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            timing_q <= `SCG_TIMING_RESET;
        else if (reinit)
            timing_q <= `SCG_TIMING_RESET;
        // RQ10 RQ13 only straight after key
        else if (acc_wr && sel_timing && unlock_q)
            timing_q <= bus.wdata[7:0];
    end

    assign timing_cfg = timing_q;

    // ****************************************
    // Interrupt status and pin
    // ****************************************
    logic irq_reset_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_reset_q <= 1'b0;
        // RQ4 set wins over clear
        else if (startup_done)
            irq_reset_q <= 1'b1;
        else if (reinit || irq_clr)
            irq_reset_q <= 1'b0;
    end

    // RQ5 RQ6 unmasked onto pin
    assign bus.irq_n = !irq_reset_q;

    // ****************************************
    // Read path
    // ****************************************
    scg_data_t rd_mux;
    scg_data_t rdata_q;
    logic      rvalid_q;

    assign rd_mux = sel_volt   ? {21'h0, volt_gain_q}   :
                    sel_chan_a ? {21'h0, chan_a_gain_q} :
                    sel_chan_b ? {21'h0, chan_b_gain_q} :
                    sel_timing ? {16'h0, timing_q}      :
                    sel_irq    ? (24'h1 << `SCG_IRQ_RESET_BIT) & {24{irq_reset_q}} :
                    24'h0;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q  <= 24'h0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= acc_rd;
            if (acc_rd)
                rdata_q <= rd_mux;
        end
    end

    assign bus.rdata  = rdata_q;
    assign bus.rvalid = rvalid_q;
endmodule : scg_device

// file: verilog/scg_host.sv
// Host end: waits for start-up, unlocks and programs timing, then relays software accesses
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_host
    import scg_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `SCG_HOST_TIMEOUT_CYC
) (
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    scg_if.host        bus,
    input  wire logic  [3:0] cmd_addr,
    input  wire logic  [23:0] cmd_wdata,
    input  wire logic  cmd_wr,
    input  wire logic  cmd_rd,
    output logic [23:0] cmd_rdata
);
    scg_host_state_e state_q;
    scg_host_state_e state_d;
    logic            tmr_done;
    logic            use_irq_q;
    scg_addr_t       dev_addr_q;
    scg_data_t       dev_wdata_q;
    scg_data_t       dev_rdata_q;
    logic [23:0]     cmd_rdata_q;
    logic            wr_q;
    logic            rd_q;
    scg_addr_t       addr_q;
    scg_data_t       wdata_q;
    logic            dev_irq;
    logic            idle;
    logic            go_wr;
    logic            go_rd;
    logic            start_ok;

    assign dev_irq  = !bus.irq_n;
    assign idle     = (state_q == SCG_HST_IDLE);
    assign go_wr    = cmd_wr && (cmd_addr == `SCG_HOFS_DEV_GO) && cmd_wdata[0] && idle;
    assign go_rd    = cmd_wr && (cmd_addr == `SCG_HOFS_DEV_GO) && cmd_wdata[1] && !cmd_wdata[0] && idle;
    // RQ7 RQ8 gate first access
    assign start_ok = use_irq_q ? dev_irq : tmr_done;

    // ****************************************
    // Bring-up sequence
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SCG_HST_WAIT:
                if (start_ok)
                    state_d = SCG_HST_KEY;
            // RQ9 RQ13 key then config back to back
            SCG_HST_KEY:
                state_d = SCG_HST_CFG;
            SCG_HST_CFG:
                state_d = SCG_HST_CLR;
            SCG_HST_CLR:
                state_d = SCG_HST_IDLE;
            SCG_HST_IDLE:
                if (use_irq_q && dev_irq && !wr_q && !rd_q)
                    state_d = SCG_HST_KEY;
            default:
                state_d = SCG_HST_WAIT;
        endcase
    end

    scg_timer #(
        .W (32)
    ) u_timeout (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clr     (1'b0),
        .limit   (TIMEOUT_CYC),
        .done    (tmr_done)
    );

    // ****************************************
    // Link drive
    // ****************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= SCG_HST_WAIT;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            wr_q    <= (state_d != SCG_HST_IDLE && state_d != SCG_HST_WAIT) || go_wr;
            rd_q    <= go_rd;
            // RQ11 key write
            if (state_d == SCG_HST_KEY)
            begin
                addr_q  <= `SCG_OFS_UNLOCK_KEY;
                wdata_q <= {16'h0, `SCG_KEY_VALUE};
            end
            // RQ12 optimum timing value
            else if (state_d == SCG_HST_CFG)
            begin
                addr_q  <= `SCG_OFS_TIMING_CFG;
                wdata_q <= {16'h0, `SCG_TIMING_OPTIMUM};
            end
            else if (state_d == SCG_HST_CLR)
            begin
                addr_q  <= `SCG_OFS_IRQ_STAT_A;
                wdata_q <= 24'h1 << `SCG_IRQ_RESET_BIT;
            end
            else if (go_wr || go_rd)
            begin
                addr_q  <= dev_addr_q;
                wdata_q <= dev_wdata_q;
            end
        end
    end

    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;

    // ****************************************
    // Command registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            use_irq_q   <= 1'b1;
            dev_addr_q  <= '0;
            dev_wdata_q <= '0;
            dev_rdata_q <= '0;
            cmd_rdata_q <= 24'h0;
        end
        else
        begin
            if (cmd_wr && cmd_addr == `SCG_HOFS_CTRL)
                use_irq_q <= cmd_wdata[0];
            if (cmd_wr && cmd_addr == `SCG_HOFS_DEV_ADDR)
                dev_addr_q <= cmd_wdata[9:0];
            if (cmd_wr && cmd_addr == `SCG_HOFS_DEV_WDATA)
                dev_wdata_q <= cmd_wdata;
            if (bus.rvalid)
                dev_rdata_q <= bus.rdata;
            if (cmd_rd)
            begin
                if (cmd_addr == `SCG_HOFS_CTRL)
                    cmd_rdata_q <= {23'h0, use_irq_q};
                else if (cmd_addr == `SCG_HOFS_STATUS)
                    cmd_rdata_q <= {21'h0, rd_q, dev_irq, idle};
                else if (cmd_addr == `SCG_HOFS_DEV_ADDR)
                    cmd_rdata_q <= {14'h0, dev_addr_q};
                else if (cmd_addr == `SCG_HOFS_DEV_WDATA)
                    cmd_rdata_q <= dev_wdata_q;
                else if (cmd_addr == `SCG_HOFS_DEV_RDATA)
                    cmd_rdata_q <= dev_rdata_q;
                else
                    cmd_rdata_q <= 24'h0;
            end
        end
    end

    assign cmd_rdata = cmd_rdata_q;
endmodule : scg_host

// file: verilog/scg_if.sv
// Register link between the host controller and the metering device
`timescale 1ns/100ps
interface scg_if;
    import scg_pkg::*;
    logic      wr;
    logic      rd;
    scg_addr_t addr;
    scg_data_t wdata;
    scg_data_t rdata;
    logic      rvalid;
    logic      irq_n;

    modport dev  (input wr, rd, addr, wdata, output rdata, rvalid, irq_n);
    modport host (output wr, rd, addr, wdata, input rdata, rvalid, irq_n);
endinterface : scg_if

// file: verilog/scg_map.svh
// Register map, field positions, reset values and timing counts for start-up and gain config
// Behaviour
// RQ1 - Stay inactive while supply below threshold
// RQ2 - Hold inactive fixed delay after threshold
// RQ3 - Enable circuitry over fixed interval, then complete
// RQ4 - Set reset flag in status on completion
// RQ5 - Reset flag drives active-low interrupt pin
// RQ6 - Reset interrupt always enabled, never maskable
// RQ7 - Host waits for reset interrupt first
// RQ8 - Without interrupt, host waits fixed timeout
// RQ9 - Host programs timing register after power-up
// RQ10 - Timing register writable only after key
// RQ11 - Host writes key to key register
// RQ12 - Host then writes optimum timing value
// RQ13 - Protected write must directly follow key
// RQ14 - Channel A gain codes 0..5, gains 1..22
// RQ15 - Channel A gain resets to code 0
// RQ16 - Gain 22 only on channel A
// RQ17 - Channel B gain codes 0..4
// RQ18 - Channel B gain resets to code 0
// RQ19 - Voltage gain codes 0..4
// RQ20 - Voltage gain resets to code 0
// RQ21 - Any other access cancels the unlock
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH

// ****************************************
// Device register offsets
// ****************************************
`define SCG_ADDR_W            10
`define SCG_DATA_W            24
`define SCG_OFS_VOLT_GAIN     10'h007
`define SCG_OFS_CHAN_A_GAIN   10'h008
`define SCG_OFS_CHAN_B_GAIN   10'h009
`define SCG_OFS_UNLOCK_KEY    10'h0fe
`define SCG_OFS_TIMING_CFG    10'h120
`define SCG_OFS_IRQ_STAT_A    10'h22d
`define SCG_OFS_IRQ_STAT_A2   10'h32d

// ****************************************
// Fields and values
// ****************************************
`define SCG_IRQ_RESET_BIT     20
`define SCG_GAIN_RESET        3'h0
`define SCG_GAIN_MAX_A        3'h5
`define SCG_GAIN_MAX_BV       3'h4
`define SCG_KEY_VALUE         8'had
`define SCG_TIMING_OPTIMUM    8'h30
`define SCG_TIMING_RESET      8'h00

// ****************************************
// Host command registers
// ****************************************
`define SCG_HOFS_CTRL         4'h0
`define SCG_HOFS_STATUS       4'h1
`define SCG_HOFS_DEV_ADDR     4'h2
`define SCG_HOFS_DEV_WDATA    4'h3
`define SCG_HOFS_DEV_GO       4'h4
`define SCG_HOFS_DEV_RDATA    4'h5

// ****************************************
// Timing
// ****************************************
`define SCG_CLK_KHZ           125000
`define SCG_HOLD_MS           26
`define SCG_ENABLE_MS         40
`define SCG_HOST_TIMEOUT_MS   100
`define SCG_HOLD_CYC          (`SCG_HOLD_MS * `SCG_CLK_KHZ)
`define SCG_ENABLE_CYC        (`SCG_ENABLE_MS * `SCG_CLK_KHZ)
`define SCG_HOST_TIMEOUT_CYC  (`SCG_HOST_TIMEOUT_MS * `SCG_CLK_KHZ)

`endif

// file: verilog/scg_pkg.sv
// Types shared by both ends of the start-up and gain config link
package scg_pkg;
    typedef logic [9:0]  scg_addr_t;
    typedef logic [23:0] scg_data_t;

    typedef enum logic [1:0] {
        SCG_DEV_OFF    = 2'h0,
        SCG_DEV_HOLD   = 2'h1,
        SCG_DEV_ENABLE = 2'h3,
        SCG_DEV_READY  = 2'h2
    } scg_dev_state_e;

    typedef enum logic [2:0] {
        SCG_HST_WAIT = 3'h0,
        SCG_HST_KEY  = 3'h1,
        SCG_HST_CFG  = 3'h3,
        SCG_HST_CLR  = 3'h2,
        SCG_HST_IDLE = 3'h6
    } scg_host_state_e;
endpackage : scg_pkg

// file: verilog/scg_timer.sv
// Restartable cycle counter for start-up delays and host timeout
`timescale 1ns/100ps
module scg_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         clr,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] count_q;

    assign done = (count_q >= limit);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            count_q <= '0;
        else if (clr)
            count_q <= '0;
        else if (!done)
            count_q <= count_q + 1'b1;
    end
endmodule : scg_timer
